/* File: shared/csp_defines.vh */
`ifndef CSP_DEFINES_VH
`define CSP_DEFINES_VH
`define CSP_STK_DEPTH 16
`define CSP_STK_AW 4
`define CSP_STK_W 15
`define CSP_PTR_W 16
`define CSP_PM_BASE 16'h8000
`define CSP_LIN_BASE 16'h2000
`define CSP_LIN_TOP 16'h29af
`define CSP_BANK_GPR 8'h50
`define CSP_BANK_OFS 7'h20
`define CSP_RCS_OVF 1
`define CSP_RCS_UNF 0
`define CSP_RCS_MASK 8'h03
`endif

/* File: rtl/csp_stack.v */
`timescale 1ns/1ps
`default_nettype none
`include "csp_defines.vh"
module csp_stack (
    input wire clk,
    input wire rst,
    input wire push,
    input wire pop,
    input wire [`CSP_STK_W-1:0] push_addr,
    output wire [`CSP_STK_W-1:0] top_addr,
    output reg ovf_r,
    output reg unf_r
);
    // ===============================
    // storage, flip-flops indexed by pointer
    reg [`CSP_STK_W-1:0] mem_r [0:`CSP_STK_DEPTH-1];
    reg [`CSP_STK_AW:0] cnt_r;
    wire full = (cnt_r == `CSP_STK_DEPTH);
    wire empty = (cnt_r == 5'h00);
    wire [`CSP_STK_AW-1:0] top_idx = cnt_r[`CSP_STK_AW-1:0] - 4'h1;
    assign top_addr = empty ? 15'h0000 : mem_r[top_idx];
    genvar i;
    generate
        for (i = 0; i < `CSP_STK_DEPTH; i = i + 1) begin : g_ent
            always @(posedge clk or posedge rst) begin
                if (rst)
                    mem_r[i] <= 15'h0000;
                else if (push && !pop && !full && cnt_r[`CSP_STK_AW-1:0] == i) // R01
                    mem_r[i] <= push_addr;
            end
        end
    endgenerate
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 5'h00;
            ovf_r <= 1'b0;
            unf_r <= 1'b0;
        end else begin
            // overflowing push is dropped, stack contents kept
            ovf_r <= push && !pop && full; // R09
            unf_r <= pop && !push && empty; // R09
            if (push && !pop && !full)
                cnt_r <= cnt_r + 5'h01;
            else if (pop && !push && !empty)
                cnt_r <= cnt_r - 5'h01;
        end
    end
endmodule // csp_stack
`default_nettype wire

/* File: rtl/csp_core_support.v */
`timescale 1ns/1ps
`default_nettype none
`include "csp_defines.vh"
// Contract
// R01: sixteen-entry fifteen-bit hardware return stack
// R02: overflow/underflow set reset-cause flags
// R03: enabled stack error forces software reset
// R04: two sixteen-bit unified indirect pointers
// R05: program-memory indirect access adds one cycle
// R06: shadow save on interrupt, restore on return
// R07: linear view of general-purpose memory
// R08: unimplemented bits read zero, writes ignored
// R09: overflow on full push, underflow empty pop
module csp_core_support (
    input wire clk,
    input wire rst,
    input wire call_push,
    input wire ret_pop,
    input wire [14:0] call_addr,
    output reg [14:0] ret_addr_r,
    input wire stack_err_rst_en,
    input wire rcs_wr,
    input wire [7:0] rcs_wdata,
    output reg [7:0] reset_cause_status_r,
    output reg soft_reset_r,
    input wire ptr_wr,
    input wire ptr_sel,
    input wire [15:0] ptr_wdata,
    input wire ptr_inc,
    output reg [15:0] indirect_pointer0_r,
    output reg [15:0] indirect_pointer1_r,
    input wire ind_req,
    input wire ind_ptr_sel,
    output reg ind_stall_r,
    output reg ind_pm_r,
    output reg [14:0] ind_addr_r,
    input wire irq_enter,
    input wire irq_return,
    input wire [7:0] ctx_w,
    input wire [7:0] ctx_status,
    input wire [7:0] ctx_bsr,
    output reg [7:0] shd_w_r,
    output reg [7:0] shd_status_r,
    output reg [7:0] shd_bsr_r,
    output reg ctx_restore_r
);
    // ===============================
    // return stack
    wire [14:0] top_addr;
    wire ovf;
    wire unf;
    csp_stack u_stack (
        .clk(clk),
        .rst(rst),
        .push(call_push),
        .pop(ret_pop),
        .push_addr(call_addr),
        .top_addr(top_addr),
        .ovf_r(ovf),
        .unf_r(unf)
    );
    // ===============================
    // stack error events
    // flags land one cycle after the offending push or pop
    wire stack_overflow_flag = ovf; // R09
    wire stack_underflow_flag = unf; // R09
    wire stack_error = stack_overflow_flag || stack_underflow_flag;
    // ===============================
    // return address
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ret_addr_r <= 15'h0000;
        end else if (ret_pop) begin
            // empty pop hands back zero, never stale data
            ret_addr_r <= top_addr; // R01
        end
    end
    // ===============================
    // reset-cause status next value
    reg [7:0] rcs_set;
    reg [7:0] rcs_kept;
    reg [7:0] reset_cause_status_nxt;
    always @* begin
        rcs_set = 8'h00;
        rcs_set[`CSP_RCS_OVF] = stack_overflow_flag; // R02
        rcs_set[`CSP_RCS_UNF] = stack_underflow_flag; // R02
        if (rcs_wr)
            rcs_kept = rcs_wdata;
        else
            rcs_kept = reset_cause_status_r;
        // set wins over a software clear in the same cycle
        reset_cause_status_nxt = (rcs_kept | rcs_set) & `CSP_RCS_MASK; // R08
    end
    // ===============================
    // reset-cause status and soft reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reset_cause_status_r <= 8'h00;
            soft_reset_r <= 1'b0;
        end else begin
            reset_cause_status_r <= reset_cause_status_nxt; // R02
            // one-cycle request; the reset controller stretches it
            soft_reset_r <= stack_err_rst_en && stack_error; // R03
        end
    end
    // ===============================
    // indirect pointers
    wire [15:0] sel_ptr = ind_ptr_sel ? indirect_pointer1_r : indirect_pointer0_r;
    // ===============================
    // pointer space decode
    wire [15:0] pm_base = `CSP_PM_BASE;
    wire [15:0] lin_base = `CSP_LIN_BASE;
    wire [15:0] lin_top = `CSP_LIN_TOP;
    wire is_pm = sel_ptr >= pm_base;
    wire is_lin = sel_ptr >= lin_base && sel_ptr <= lin_top;
    wire [15:0] bank_size = {8'h00, `CSP_BANK_GPR};
    wire [15:0] bank_ofs = {9'h000, `CSP_BANK_OFS};
    wire [15:0] lin_ofs = sel_ptr - lin_base;
    // constant divide; cheap at this width
    wire [15:0] lin_bank = lin_ofs / bank_size;
    wire [15:0] lin_low = lin_ofs - lin_bank * bank_size;
    wire [15:0] lin_phys = {lin_bank[8:0], 7'h00} + lin_low + bank_ofs;
    // ===============================
    // pointer registers, a write wins over an increment
    reg [15:0] indirect_pointer0_nxt;
    reg [15:0] indirect_pointer1_nxt;
    always @* begin
        indirect_pointer0_nxt = indirect_pointer0_r;
        indirect_pointer1_nxt = indirect_pointer1_r;
        if (ptr_wr) begin
            if (ptr_sel)
                indirect_pointer1_nxt = ptr_wdata; // R04
            else
                indirect_pointer0_nxt = ptr_wdata; // R04
        end else if (ptr_inc) begin
            if (ptr_sel)
                indirect_pointer1_nxt = indirect_pointer1_r + 16'h0001;
            else
                indirect_pointer0_nxt = indirect_pointer0_r + 16'h0001;
        end
    end
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            indirect_pointer0_r <= 16'h0000;
            indirect_pointer1_r <= 16'h0000;
        end else begin
            indirect_pointer0_r <= indirect_pointer0_nxt;
            indirect_pointer1_r <= indirect_pointer1_nxt;
        end
    end
    // ===============================
    // indirect access sequencer, one-hot
    localparam [1:0] IND_RUN = 2'b01;
    localparam [1:0] IND_FETCH = 2'b10;
    reg [1:0] ind_state_r;
    reg [1:0] ind_state_nxt;
    reg [14:0] ind_addr_nxt;
    wire pm_access = ind_req && is_pm;
    always @* begin
        ind_state_nxt = IND_RUN;
        case (ind_state_r)
            IND_RUN: begin
                // program memory word needs a second cycle
                if (pm_access)
                    ind_state_nxt = IND_FETCH; // R05
                else
                    ind_state_nxt = IND_RUN;
            end
            IND_FETCH: begin
                // one extra cycle only, even with the request held
                ind_state_nxt = IND_RUN; // R05
            end
            default: begin
                ind_state_nxt = IND_RUN;
            end
        endcase
    end
    wire ind_fetch_next = (ind_state_nxt == IND_FETCH);
    always @* begin
        ind_addr_nxt = ind_addr_r;
        if (ind_req) begin
            if (is_pm)
                ind_addr_nxt = sel_ptr[14:0]; // R04
            else if (is_lin)
                ind_addr_nxt = lin_phys[14:0]; // R07
            else
                ind_addr_nxt = sel_ptr[14:0]; // R04
        end
    end
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ind_state_r <= IND_RUN;
            ind_stall_r <= 1'b0;
            ind_pm_r <= 1'b0;
            ind_addr_r <= 15'h0000;
        end else begin
            ind_state_r <= ind_state_nxt;
            ind_stall_r <= ind_fetch_next; // R05
            ind_pm_r <= pm_access;
            ind_addr_r <= ind_addr_nxt;
        end
    end
    // ===============================
    // interrupt context shadows
    // a nested entry overwrites the saved context
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            shd_w_r <= 8'h00;
            shd_status_r <= 8'h00;
            shd_bsr_r <= 8'h00;
        end else if (irq_enter) begin
            shd_w_r <= ctx_w; // R06
            shd_status_r <= ctx_status; // R06
            shd_bsr_r <= ctx_bsr; // R06
        end
    end
    // ===============================
    // restore strobe, shadows go back while high
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctx_restore_r <= 1'b0;
        end else begin
            ctx_restore_r <= irq_return; // R06
        end
    end
endmodule // csp_core_support
`default_nettype wire

/* File: sim/csp_core_support_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// stack, pointer and context checks
module csp_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic irq_enter,
    input wire logic irq_return,
    input wire logic [7:0] ctx_w,
    input wire logic [7:0] shd_w_r,
    input wire logic ctx_restore_r,
    input wire logic ptr_wr,
    input wire logic ptr_sel,
    input wire logic [15:0] ptr_wdata,
    input wire logic [15:0] indirect_pointer0_r,
    input wire logic ind_stall_r,
    input wire logic ind_pm_r,
    input wire logic rcs_wr,
    input wire logic [7:0] reset_cause_status_r,
    input wire logic soft_reset_r,
    input wire logic stack_err_rst_en,
    input wire logic ind_req,
    input wire logic ind_ptr_sel,
    input wire logic [15:0] indirect_pointer1_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_rcs_unimpl_zero: assert property (reset_cause_status_r[7:2] == 6'h00)
        else $error("rcs high bits set");
    a_ovf_flag_sticky: assert property (reset_cause_status_r[1] && !rcs_wr |=> reset_cause_status_r[1])
        else $error("overflow flag lost");
    a_soft_rst_cause: assert property ($rose(soft_reset_r) |-> |reset_cause_status_r[1:0])
        else $error("soft reset without flag");
    a_stall_pm_only: assert property (ind_stall_r |-> ind_pm_r)
        else $error("stall without pm target");
    a_stall_one_cycle: assert property (ind_stall_r |=> !ind_stall_r)
        else $error("stall too long");
    a_restore_next: assert property (irq_return |=> ctx_restore_r)
        else $error("no restore");
    a_shadow_take: assert property (irq_enter |=> shd_w_r == $past(ctx_w))
        else $error("shadow not taken");
    a_ptr_load: assert property (ptr_wr && !ptr_sel |=> indirect_pointer0_r == $past(ptr_wdata))
        else $error("pointer not loaded");
    a_stall_on_pm: assert property (ind_req && !ind_stall_r &&
        (ind_ptr_sel ? indirect_pointer1_r[15] : indirect_pointer0_r[15]) |=> ind_stall_r)
        else $error("no stall for pm target");
    a_soft_rst_gated: assert property (soft_reset_r |-> $past(stack_err_rst_en))
        else $error("soft reset while disabled");
    cover property (soft_reset_r);
    cover property (ind_stall_r);
    cover property (ctx_restore_r);
    cover property (reset_cause_status_r[0]);
endmodule // csp_chk
bind csp_core_support csp_chk chk_u (
    .clk(clk),
    .rst(rst),
    .irq_enter(irq_enter),
    .irq_return(irq_return),
    .ctx_w(ctx_w),
    .shd_w_r(shd_w_r),
    .ctx_restore_r(ctx_restore_r),
    .ptr_wr(ptr_wr),
    .ptr_sel(ptr_sel),
    .ptr_wdata(ptr_wdata),
    .indirect_pointer0_r(indirect_pointer0_r),
    .ind_stall_r(ind_stall_r),
    .ind_pm_r(ind_pm_r),
    .rcs_wr(rcs_wr),
    .reset_cause_status_r(reset_cause_status_r),
    .soft_reset_r(soft_reset_r),
    .stack_err_rst_en(stack_err_rst_en),
    .ind_req(ind_req),
    .ind_ptr_sel(ind_ptr_sel),
    .indirect_pointer1_r(indirect_pointer1_r)
);
`default_nettype wire

/* File: sim/csp_core_support_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// bench top
module csp_core_support_test;
    logic clk, rst, call_push, ret_pop, stack_err_rst_en, rcs_wr, ptr_wr, ptr_sel, ptr_inc, ind_req, ind_ptr_sel;
    logic irq_enter, irq_return, soft_reset_r, ind_stall_r, ind_pm_r, ctx_restore_r;
    logic [14:0] call_addr, ret_addr_r, ind_addr_r;
    logic [7:0] rcs_wdata, reset_cause_status_r, ctx_w, ctx_status, ctx_bsr, shd_w_r, shd_status_r, shd_bsr_r;
    logic [15:0] ptr_wdata, indirect_pointer0_r, indirect_pointer1_r;
    int bad_count = 0, check_count = 0, cyc = 0;
    csp_core_support dut_u (
        .clk(clk),
        .rst(rst),
        .call_push(call_push),
        .ret_pop(ret_pop),
        .call_addr(call_addr),
        .ret_addr_r(ret_addr_r),
        .stack_err_rst_en(stack_err_rst_en),
        .rcs_wr(rcs_wr),
        .rcs_wdata(rcs_wdata),
        .reset_cause_status_r(reset_cause_status_r),
        .soft_reset_r(soft_reset_r),
        .ptr_wr(ptr_wr),
        .ptr_sel(ptr_sel),
        .ptr_wdata(ptr_wdata),
        .ptr_inc(ptr_inc),
        .indirect_pointer0_r(indirect_pointer0_r),
        .indirect_pointer1_r(indirect_pointer1_r),
        .ind_req(ind_req),
        .ind_ptr_sel(ind_ptr_sel),
        .ind_stall_r(ind_stall_r),
        .ind_pm_r(ind_pm_r),
        .ind_addr_r(ind_addr_r),
        .irq_enter(irq_enter),
        .irq_return(irq_return),
        .ctx_w(ctx_w),
        .ctx_status(ctx_status),
        .ctx_bsr(ctx_bsr),
        .shd_w_r(shd_w_r),
        .shd_status_r(shd_status_r),
        .shd_bsr_r(shd_bsr_r),
        .ctx_restore_r(ctx_restore_r)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // 17 pushes: last one overflows and is dropped
    task automatic t_stack;
        for (int i = 0; i < 17; i++) begin
            @(posedge clk); call_push <= 1'b1; call_addr <= 15'h4000 + i[14:0];
        end
        @(posedge clk); call_push <= 1'b0;
        @(posedge clk);
        #1 chk(reset_cause_status_r, 16'h2);
        chk(soft_reset_r, 1'b1);
        @(posedge clk);
        #1 chk(soft_reset_r, 1'b0);
        @(posedge clk); rcs_wr <= 1'b1; rcs_wdata <= 8'hfc; stack_err_rst_en <= 1'b0;
        @(posedge clk); rcs_wr <= 1'b0;
        #1 chk(reset_cause_status_r, 16'h0);
        // empty pop last: returns zero
        for (int j = 0; j < 17; j++) begin
            @(posedge clk); ret_pop <= 1'b1;
            @(posedge clk); ret_pop <= 1'b0;
            #1 chk(ret_addr_r, j < 16 ? 15'h400f - j[14:0] : 15'h0);
        end
        @(posedge clk);
        #1 chk(reset_cause_status_r, 16'h1);
        chk(soft_reset_r, 1'b0);
    endtask
    task automatic t_ptr;
        @(posedge clk); ptr_wr <= 1'b1; ptr_sel <= 1'b0; ptr_wdata <= 16'h8010;
        @(posedge clk); ptr_sel <= 1'b1; ptr_wdata <= 16'h2050;
        @(posedge clk); ptr_wr <= 1'b0; ind_req <= 1'b1; ind_ptr_sel <= 1'b0;
        @(posedge clk); ind_req <= 1'b0;
        #1 chk(indirect_pointer1_r, 16'h2050);
        chk(indirect_pointer0_r, 16'h8010);
        chk({ind_stall_r, ind_pm_r, ind_addr_r}, 17'h18010);
        @(posedge clk); ind_req <= 1'b1; ind_ptr_sel <= 1'b1;
        @(posedge clk); ind_req <= 1'b0;
        #1 chk({ind_stall_r, ind_pm_r, ind_addr_r}, 16'h00a0);
        @(posedge clk); ptr_inc <= 1'b1;
        @(posedge clk); ptr_inc <= 1'b0; ind_req <= 1'b1; ind_ptr_sel <= 1'b0;
        #1 chk(indirect_pointer1_r, 16'h2051);
        @(posedge clk);
        #1 chk({ind_stall_r, ind_pm_r}, 2'h3);
        @(posedge clk); ind_req <= 1'b0;
        #1 chk({ind_stall_r, ind_pm_r}, 2'h1);
    endtask
    task automatic t_irq;
        @(posedge clk); irq_enter <= 1'b1; ctx_w <= 8'h5a; ctx_status <= 8'h13; ctx_bsr <= 8'h07;
        @(posedge clk); irq_enter <= 1'b0; ctx_w <= 8'h00; irq_return <= 1'b1;
        @(posedge clk); irq_return <= 1'b0;
        #1 chk({shd_w_r, shd_status_r}, 16'h5a13);
        chk({ctx_restore_r, shd_bsr_r}, 16'h107);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        {rst, call_push, ret_pop, rcs_wr, ptr_wr, ptr_sel, ptr_inc, ind_req, ind_ptr_sel} = 9'h100;
        {irq_enter, irq_return, call_addr, rcs_wdata, ptr_wdata} = '0;
        {ctx_w, ctx_status, ctx_bsr} = '0;
        stack_err_rst_en = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_stack();
        t_ptr();
        t_irq();
        complete_run();
    end
endmodule // csp_core_support_test
`default_nettype wire
